/* File: hw/sidfc_pkg.sv */
// Package of constants for the switch-input diagnostic and filter configuration block.
package sidfc_pkg;

	// ==========================================================
	// Field positions in the configuration word.
	localparam int unsigned CFG_WET_DIAG_LSB   = 18;
	localparam int unsigned CFG_SUPPLY_MEAS    = 17;
	localparam int unsigned CFG_THERM_DIS_SINK = 16;
	localparam int unsigned CFG_DEPTH_MSB      = 15;
	localparam int unsigned CFG_DEPTH_LSB      = 14;
	localparam int unsigned CFG_THERM_DIS_SRC  = 13;
	localparam int unsigned CFG_WIDTH          = 21;
	localparam logic [20:0] CFG_RESET          = 21'h000000;

	// ==========================================================
	// Wetting current codes.
	localparam int unsigned CUR_W   = 3;
	localparam logic [2:0]  CUR_0MA  = 3'h0;
	localparam logic [2:0]  CUR_1MA  = 3'h1;
	localparam logic [2:0]  CUR_2MA  = 3'h2;
	localparam logic [2:0]  CUR_5MA  = 3'h3;
	localparam logic [2:0]  CUR_10MA = 3'h4;
	localparam logic [2:0]  CUR_15MA = 3'h5;

	localparam int unsigned DEPTH_W = 2;
	localparam int unsigned NUM_DIAG_INPUTS = 3;

endpackage

/* File: hw/sidfc_debounce.sv */
// Per-input sample debounce filter.
`timescale 1ns/100ps
`default_nettype none
module sidfc_debounce
	import sidfc_pkg::*;
(
	// Clock and reset.
	input  wire logic               clk_i,
	input  wire logic               reset_i,
	// Sample stream.
	input  wire logic               sample_valid_i,
	input  wire logic               sample_i,
	input  wire logic [DEPTH_W-1:0] depth_i,
	// Filtered result.
	output logic                    state_o,
	output logic                    update_o
);

	typedef struct packed {
		logic               primed;
		logic               prev;
		logic [DEPTH_W-1:0] count;
		logic               state;
		logic               update;
	} sidfc_deb_s;

	sidfc_deb_s s_q;
	sidfc_deb_s s_d;

	always_comb begin
		s_d        = s_q;
		s_d.update = 1'b0;
		if (sample_valid_i) begin
			s_d.primed = 1'b1;
			s_d.prev   = sample_i;
			// The first sample after reset has no predecessor, so it always starts a fresh run.
			if (!s_q.primed || (sample_i != s_q.prev)) begin
				s_d.count = '0;
			end else if (s_q.count != {DEPTH_W{1'b1}}) begin
				s_d.count = s_q.count + 1'b1;
			end
			// The count holds the matches beyond the first sample.
			if (s_d.count >= depth_i) begin
				s_d.state  = sample_i;
				s_d.update = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign state_o  = s_q.state;
	assign update_o = s_q.update;

endmodule
`default_nettype wire

/* File: hw/sidfc_top.sv */
// Configuration, thermal current reduction and filtering for the switch-input monitor.
`timescale 1ns/100ps
`default_nettype none
module sidfc_top
	import sidfc_pkg::*;
#(
	parameter int unsigned N_INPUTS = 4
) (
	// Clock and reset.
	input  wire logic                                  clk_i,
	input  wire logic                                  reset_i,

	// Configuration write.
	input  wire logic                                  cfg_write_i,
	input  wire logic [sidfc_pkg::CFG_WIDTH-1:0]       cfg_wdata_i,

	// Configuration readback and field outputs.
	output logic      [sidfc_pkg::CFG_WIDTH-1:0]       cfg_rdata_o,
	output logic      [sidfc_pkg::NUM_DIAG_INPUTS-1:0] wet_diag_enable_o,

	// Polling and supply measurement.
	input  wire logic                                  poll_end_i,
	output logic                                       supply_measure_start_o,

	// Wetting current control.
	input  wire logic                                  thermal_warning_i,
	input  wire logic [N_INPUTS-1:0]                   current_source_mode_i,
	input  wire logic [N_INPUTS*sidfc_pkg::CUR_W-1:0]  current_set_i,
	output logic      [N_INPUTS*sidfc_pkg::CUR_W-1:0]  current_applied_o,

	// Samples and filtered state.
	input  wire logic                                  sample_valid_i,
	input  wire logic [N_INPUTS-1:0]                   sample_i,
	output logic      [N_INPUTS-1:0]                   filtered_state_o,
	output logic      [N_INPUTS-1:0]                   filtered_update_o
);
	import sidfc_pkg::*;

	// ==========================================================
	// Configuration word layout.
	// The word is kept as separate fields so that each consumer reads its field by name.
	// Bits below the source-group disable bit have no function here and are stored as written.
	localparam int unsigned SPARE_W = CFG_THERM_DIS_SRC;

	// ==========================================================
	// Types.
	typedef struct packed {
		logic [NUM_DIAG_INPUTS-1:0] wet_diag;
		logic                       supply_meas_en;
		logic                       therm_dis_sink;
		logic [DEPTH_W-1:0]         depth;
		logic                       therm_dis_src;
		logic [SPARE_W-1:0]         spare;
	} sidfc_cfg_s;

	// All state of the block except that of the per-input filters.
	typedef struct packed {
		sidfc_cfg_s                 cfg;
		logic                       meas;
		logic [N_INPUTS*CUR_W-1:0]  cur;
	} sidfc_top_s;

	sidfc_top_s                 s_q;
	sidfc_top_s                 s_d;
	logic [CUR_W-1:0]           cur_next [N_INPUTS];
	logic [N_INPUTS-1:0]        deb_state;
	logic [N_INPUTS-1:0]        deb_update;

	// ==========================================================
	// Decoding functions.

	// Splits a configuration word into its fields.
	function automatic sidfc_cfg_s unpack_cfg(input logic [CFG_WIDTH-1:0] w);
		sidfc_cfg_s f;
		f.wet_diag       = w[CFG_WET_DIAG_LSB +: NUM_DIAG_INPUTS];
		f.supply_meas_en = w[CFG_SUPPLY_MEAS];
		f.therm_dis_sink = w[CFG_THERM_DIS_SINK];
		f.depth          = w[CFG_DEPTH_MSB:CFG_DEPTH_LSB];
		f.therm_dis_src  = w[CFG_THERM_DIS_SRC];
		f.spare          = w[SPARE_W-1:0];
		return f;
	endfunction

	// Builds the readback word from the stored fields.
	function automatic logic [CFG_WIDTH-1:0] pack_cfg(input sidfc_cfg_s f);
		logic [CFG_WIDTH-1:0] w;
		w                                      = '0;
		w[CFG_WET_DIAG_LSB +: NUM_DIAG_INPUTS] = f.wet_diag;
		w[CFG_SUPPLY_MEAS]                     = f.supply_meas_en;
		w[CFG_THERM_DIS_SINK]                  = f.therm_dis_sink;
		w[CFG_DEPTH_MSB:CFG_DEPTH_LSB]         = f.depth;
		w[CFG_THERM_DIS_SRC]                   = f.therm_dis_src;
		w[SPARE_W-1:0]                         = f.spare;
		return w;
	endfunction

	// Reports whether a current code is one of the settings that a thermal warning cuts.
	function automatic logic is_high_current(input logic [CUR_W-1:0] c);
		logic hit;
		hit = 1'b0;
		unique case (c)
			CUR_0MA,
			CUR_1MA,
			CUR_2MA,
			CUR_5MA: begin
				hit = 1'b0;
			end
			CUR_10MA,
			CUR_15MA: begin
				hit = 1'b1;
			end
			// Codes above the highest setting are undefined and are passed on untouched.
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	// Tells whether the group of an input lets a thermal warning cut its current.
	function automatic logic reduce_allowed(input logic source_mode, input sidfc_cfg_s f);
		logic allowed;
		if (source_mode) begin
			allowed = !f.therm_dis_src;
		end else begin
			allowed = !f.therm_dis_sink;
		end
		return allowed;
	endfunction

	// ==========================================================
	// Thermal wetting current reduction, one slice per input.
	// The cut is decided afresh on every cycle, so the programmed setting returns once the warning ends.
	genvar gc;
	generate
		for (gc = 0; gc < N_INPUTS; gc++) begin : g_cur
			logic [CUR_W-1:0] set_code;
			logic [CUR_W-1:0] applied;
			logic             high;
			logic             allowed;
			logic             cut;
			assign set_code = current_set_i[gc*CUR_W +: CUR_W];
			assign high     = is_high_current(set_code);
			assign allowed  = reduce_allowed(current_source_mode_i[gc], s_q.cfg);
			assign cut      = thermal_warning_i && high && allowed;
			always_comb begin
				if (cut) begin
					applied = CUR_2MA;
				end else begin
					applied = set_code;
				end
			end
			assign cur_next[gc] = applied;
		end
	endgenerate

	// ==========================================================
	// Next state.
	always_comb begin
		s_d = s_q;

		// Configuration fields are replaced whole on a write.
		if (cfg_write_i) begin
			s_d.cfg = unpack_cfg(cfg_wdata_i);
		end

		// A write in the same cycle as the end of a poll takes effect from the next poll on.
		if (poll_end_i && s_q.cfg.supply_meas_en) begin
			s_d.meas = 1'b1;
		end else begin
			s_d.meas = 1'b0;
		end

		// Wetting current follows the inputs with one cycle of lag.
		for (int i = 0; i < N_INPUTS; i++) begin
			s_d.cur[i*CUR_W +: CUR_W] = cur_next[i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_q <= '{cfg: unpack_cfg(CFG_RESET), meas: 1'b0, cur: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Per-input filters.
	// Every input runs its own filter; all of them share the depth field.
	genvar gf;
	generate
		for (gf = 0; gf < N_INPUTS; gf++) begin : g_deb
			sidfc_debounce u_sidfc_debounce (
				.clk_i          (clk_i),
				.reset_i        (reset_i),
				.sample_valid_i (sample_valid_i),
				.sample_i       (sample_i[gf]),
				.depth_i        (s_q.cfg.depth),
				.state_o        (deb_state[gf]),
				.update_o       (deb_update[gf])
			);
		end
	endgenerate

	// ==========================================================
	// Outputs.
	// Configuration readback and its decoded fields.
	assign cfg_rdata_o            = pack_cfg(s_q.cfg);
	assign wet_diag_enable_o      = s_q.cfg.wet_diag;

	// Supply measurement request.
	assign supply_measure_start_o = s_q.meas;

	// Wetting current after thermal reduction.
	assign current_applied_o      = s_q.cur;

	// Filter results.
	assign filtered_state_o       = deb_state;
	assign filtered_update_o      = deb_update;

endmodule
`default_nettype wire

/* File: testbench/sidfc_sva.sv */
// Checker of the switch-input configuration block ports.
`timescale 1ns/100ps
`default_nettype none
module sidfc_sva #(parameter int unsigned N_INPUTS = 4) (
	input wire logic clk_i, reset_i, cfg_write_i, poll_end_i, thermal_warning_i, sample_valid_i,
	input wire logic [20:0] cfg_wdata_i, cfg_rdata_o,
	input wire logic [2:0] wet_diag_enable_o,
	input wire logic supply_measure_start_o,
	input wire logic [N_INPUTS-1:0] current_source_mode_i, sample_i, filtered_state_o, filtered_update_o,
	input wire logic [N_INPUTS*3-1:0] current_set_i, current_applied_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	rst_zero_a: assert property (disable iff (1'h0) reset_i |=> cfg_rdata_o == 21'h0) else $error("no reset");
	cfg_load_a: assert property (cfg_write_i |=> cfg_rdata_o == $past(cfg_wdata_i)) else $error("no load");
	diag_map_a: assert property (cfg_write_i |=> wet_diag_enable_o == $past(cfg_wdata_i[20:18])) else $error("diag");
	supply_go_a: assert property (supply_measure_start_o == $past(poll_end_i & cfg_rdata_o[17] & !reset_i))
		else $error("supply");
	sink_cut_a: assert property (thermal_warning_i && !current_source_mode_i[0] && !cfg_rdata_o[16]
		&& (current_set_i[2:0] == 3'h4 || current_set_i[2:0] == 3'h5) |=> current_applied_o[2:0] == 3'h2)
		else $error("sink cut");
	src_keep_a: assert property (current_source_mode_i[1] && cfg_rdata_o[13]
		|=> current_applied_o[5:3] == $past(current_set_i[5:3])) else $error("source keep");
	filt_pass_a: assert property (sample_valid_i && cfg_rdata_o[15:14] == 2'h0
		|=> filtered_state_o == $past(sample_i)) else $error("depth zero");
	filt_idle_a: assert property (!sample_valid_i |=> filtered_update_o == '0 && $stable(filtered_state_o))
		else $error("idle filter");
endmodule
bind sidfc_top sidfc_sva #(.N_INPUTS(N_INPUTS)) u_sidfc_sva (
	.clk_i(clk_i), .reset_i(reset_i), .cfg_write_i(cfg_write_i), .poll_end_i(poll_end_i),
	.thermal_warning_i(thermal_warning_i), .sample_valid_i(sample_valid_i), .cfg_wdata_i(cfg_wdata_i),
	.cfg_rdata_o(cfg_rdata_o), .wet_diag_enable_o(wet_diag_enable_o), .supply_measure_start_o(supply_measure_start_o),
	.current_source_mode_i(current_source_mode_i), .sample_i(sample_i), .filtered_state_o(filtered_state_o),
	.filtered_update_o(filtered_update_o), .current_set_i(current_set_i), .current_applied_o(current_applied_o)
);
`default_nettype wire

/* File: testbench/sidfc_top_tb.sv */
// Self-checking bench of the switch-input configuration block.
`timescale 1ns/100ps
`default_nettype none
module sidfc_top_tb;
	import sidfc_pkg::*;
	logic clk_i = 1'h0, reset_i = 1'h1, cfg_write_i = 1'h0, poll_end_i = 1'h0;
	logic thermal_warning_i = 1'h0, sample_valid_i = 1'h0, supply_measure_start_o;
	logic [20:0] cfg_wdata_i = 21'h0, cfg_rdata_o;
	logic [2:0] wet_diag_enable_o;
	logic [3:0] current_source_mode_i = 4'h2, sample_i = 4'h0, filtered_state_o, filtered_update_o;
	logic [11:0] current_set_i = 12'hAEC, current_applied_o;
	int error_cnt = 0, compares = 0;
	sidfc_top #(.N_INPUTS(4)) u_sidfc_top (
		.clk_i                  (clk_i),
		.reset_i                (reset_i),
		.cfg_write_i            (cfg_write_i),
		.cfg_wdata_i            (cfg_wdata_i),
		.cfg_rdata_o            (cfg_rdata_o),
		.wet_diag_enable_o      (wet_diag_enable_o),
		.poll_end_i             (poll_end_i),
		.supply_measure_start_o (supply_measure_start_o),
		.thermal_warning_i      (thermal_warning_i),
		.current_source_mode_i  (current_source_mode_i),
		.current_set_i          (current_set_i),
		.current_applied_o      (current_applied_o),
		.sample_valid_i         (sample_valid_i),
		.sample_i               (sample_i),
		.filtered_state_o       (filtered_state_o),
		.filtered_update_o      (filtered_update_o)
	);
	always #5 clk_i = ~clk_i;
	task automatic chk(input string n, input logic [20:0] e, s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [20:0] d);
		@(posedge clk_i);
		cfg_write_i <= 1'h1;
		cfg_wdata_i <= d;
		@(posedge clk_i);
		cfg_write_i <= 1'h0;
		#1;
	endtask
	task automatic smp(input logic [3:0] v);
		@(posedge clk_i);
		sample_valid_i <= 1'h1;
		sample_i <= v;
		@(posedge clk_i);
		sample_valid_i <= 1'h0;
		#1;
	endtask
	task automatic t_cfg;
		chk("rdata", 21'h0, cfg_rdata_o);
		wr(21'h1DE000);
		chk("rdata", 21'h1DE000, cfg_rdata_o);
		chk("diag", 21'h7, wet_diag_enable_o);
		wr(21'h080000);
		chk("diag", 21'h2, wet_diag_enable_o);
	endtask
	task automatic t_supply;
		for (int i = 0; i < 2; i++) begin
			wr({3'h0, i[0], 17'h0});
			@(posedge clk_i);
			poll_end_i <= 1'h1;
			@(posedge clk_i);
			poll_end_i <= 1'h0;
			#1;
			chk("supply", {20'h0, i[0]}, supply_measure_start_o);
			@(posedge clk_i);
			#1;
			chk("supply", 21'h0, supply_measure_start_o);
		end
	endtask
	task automatic t_therm;
		logic [20:0] c [3] = '{21'h0, 21'h010000, 21'h002000};
		logic [11:0] x [3] = '{12'h4D2, 12'hAD4, 12'h4EA};
		for (int i = 0; i < 3; i++) begin
			wr(c[i]);
			@(posedge clk_i);
			thermal_warning_i <= 1'h1;
			@(posedge clk_i);
			thermal_warning_i <= 1'h0;
			#1;
			chk("cur", x[i], current_applied_o);
			@(posedge clk_i);
			#1;
			chk("cur", 21'hAEC, current_applied_o);
		end
	endtask
	task automatic t_filt;
		smp(4'h5);
		chk("filt", 21'h5, filtered_state_o);
		chk("upd", 21'hF, filtered_update_o);
		wr(21'h004000);
		smp(4'hA);
		chk("filt", 21'h5, filtered_state_o);
		chk("upd", 21'h0, filtered_update_o);
		smp(4'hA);
		chk("filt", 21'hA, filtered_state_o);
		chk("upd", 21'hF, filtered_update_o);
		wr(21'h00C000);
		for (int i = 0; i < 4; i++) begin
			smp(4'h5);
			chk("filt", (i < 3) ? 21'hA : 21'h5, filtered_state_o);
			chk("upd", (i < 3) ? 21'h0 : 21'hF, filtered_update_o);
		end
	endtask
	task automatic end_of_test;
		$display("error_cnt %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'h0;
		#1;
		t_cfg;
		t_supply;
		t_therm;
		t_filt;
		end_of_test;
	end
endmodule
`default_nettype wire
